/* include/idp_pkg.sv */
// constants and types shared by the isolated/ttl digital i/o port
package idp_pkg;
    // ======================================================
    // register offsets within the four-byte block
    localparam logic [1:0] OFS_ISO_LO = 2'h0;
    localparam logic [1:0] OFS_ISO_HI = 2'h1;
    localparam logic [1:0] OFS_TTL_LO = 2'h2;
    localparam logic [1:0] OFS_TTL_HI = 2'h3;
    // ======================================================
    // address decode: lines a9..a2 select the block
    localparam int ADDR_W = 10;
    localparam int BASE_MSB = 9;
    localparam int BASE_LSB = 2;
    localparam int OFS_MSB = 1;
    localparam logic [7:0] BASE_DEFAULT = 8'hC0;
    // ======================================================
    // byte and port widths
    localparam int BYTE_W = 8;
    localparam int PORT_W = 16;
    localparam logic [15:0] OUT_RESET = 16'h0000;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // ======================================================
    // interrupt configuration encodings
    typedef enum logic [1:0] {
        SRC_ISO_CH0 = 2'h0,
        SRC_ISO_CH1 = 2'h1,
        SRC_TTL_CH0 = 2'h2,
        SRC_TTL_CH1 = 2'h3
    } idp_src_type;
    localparam logic EDGE_RISING = 1'b0;
    localparam logic EDGE_FALLING = 1'b1;
    localparam logic [2:0] IRQ_LINE_MIN = 3'h2;
    localparam logic [2:0] IRQ_LINE_MAX = 3'h7;
    localparam int IRQ_LINES = 6;
    localparam logic [5:0] IRQ_IDLE = 6'h00;
    localparam logic [5:0] IRQ_ONE = 6'h01;
endpackage : idp_pkg

/* include/idp_wr_if.sv */
// carrier between bus front end and output latches
`timescale 1ns/100ps
interface idp_wr_if;
    logic wr_en;
    logic [1:0] wr_ofs;
    logic [7:0] wr_data;
    logic [15:0] iso_q;
    logic [15:0] ttl_q;
    modport ctl (output wr_en, output wr_ofs, output wr_data,
        input iso_q, input ttl_q);
    modport lat (input wr_en, input wr_ofs, input wr_data,
        output iso_q, output ttl_q);
endinterface : idp_wr_if

/* design/idp_out_latch.sv */
// output byte latches for isolated and ttl output ports
`timescale 1ns/100ps
module idp_out_latch (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // write side
    idp_wr_if.lat wr
);
    typedef struct packed {
        logic [15:0] iso;
        logic [15:0] ttl;
    } idp_lat_type;

    idp_lat_type st_r;
    idp_lat_type st_nxt;

    // ======================================================
    // byte steering: each write touches only its own byte
    always_comb begin
        st_nxt = st_r;
        if (wr.wr_en) begin
            case (wr.wr_ofs)
                idp_pkg::OFS_ISO_LO: st_nxt.iso[7:0] = wr.wr_data;
                idp_pkg::OFS_ISO_HI: st_nxt.iso[15:8] = wr.wr_data;
                idp_pkg::OFS_TTL_LO: st_nxt.ttl[7:0] = wr.wr_data;
                idp_pkg::OFS_TTL_HI: st_nxt.ttl[15:8] = wr.wr_data;
                default: st_nxt = st_r;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r.iso <= idp_pkg::OUT_RESET;
            st_r.ttl <= idp_pkg::OUT_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // a one bit turns the channel on, zero turns it off
    assign wr.iso_q = st_r.iso;
    assign wr.ttl_q = st_r.ttl;
endmodule : idp_out_latch

/* design/idp_top.sv */
// isolated and ttl digital i/o port with one edge interrupt
`timescale 1ns/100ps
// Functional notes
// - interrupt comes from one selected input channel
// - channels 0-7 low byte, 8-15 high byte
// - written one turns output on, zero off
// - reads return live input states
// - isolated at base+0/1, ttl at base+2/3
// - rising or falling edge selectable, rising default
// - irq routed to line 2..7 or disabled
// - a9..a2 matched against configured base
module idp_top (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET,
    // host i/o bus
    input wire logic [9:0] ADDR,
    input wire logic AEN,
    input wire logic IOW_N,
    input wire logic IOR_N,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    // configuration straps
    input wire logic [7:0] BASE_ADDRESS_SELECT,
    input wire logic [1:0] INTERRUPT_SOURCE_SELECT,
    input wire logic INTERRUPT_EDGE_SELECT,
    input wire logic [2:0] INTERRUPT_LINE_SELECT,
    // channel pins
    input wire logic [15:0] ISOLATED_INPUT_BITS,
    input wire logic [15:0] TTL_INPUT_BITS,
    output logic [15:0] ISOLATED_OUTPUT_BITS,
    output logic [15:0] TTL_OUTPUT_BITS,
    // interrupt request lines 2..7
    output logic [5:0] IRQ_LINES
);
    typedef struct packed {
        logic iow_prev;
        logic src_prev;
        logic [7:0] rdata;
        logic rd_oe;
        logic [5:0] irq;
    } idp_state_type;

    idp_state_type st_r;
    idp_state_type st_nxt;

    idp_wr_if wr ();

    // ======================================================
    // helpers
    function automatic logic block_hit(input logic [9:0] a,
        input logic aen, input logic [7:0] base);
        block_hit = !aen
            && (a[idp_pkg::BASE_MSB:idp_pkg::BASE_LSB] == base);
    endfunction : block_hit

    function automatic logic [7:0] in_byte(input logic [1:0] ofs,
        input logic [15:0] iso, input logic [15:0] ttl);
        case (ofs)
            idp_pkg::OFS_ISO_LO: in_byte = iso[7:0];
            idp_pkg::OFS_ISO_HI: in_byte = iso[15:8];
            idp_pkg::OFS_TTL_LO: in_byte = ttl[7:0];
            idp_pkg::OFS_TTL_HI: in_byte = ttl[15:8];
            default: in_byte = idp_pkg::DATA_RESET;
        endcase
    endfunction : in_byte

    function automatic logic src_bit(input logic [1:0] sel,
        input logic [15:0] iso, input logic [15:0] ttl);
        case (sel)
            idp_pkg::SRC_ISO_CH0: src_bit = iso[0];
            idp_pkg::SRC_ISO_CH1: src_bit = iso[1];
            idp_pkg::SRC_TTL_CH0: src_bit = ttl[0];
            idp_pkg::SRC_TTL_CH1: src_bit = ttl[1];
            default: src_bit = 1'b0;
        endcase
    endfunction : src_bit

    // ======================================================
    // combinational next state
    logic hit;
    logic wr_pulse;
    logic src_now;
    logic edge_seen;
    logic [2:0] line_idx;

    always_comb begin
        hit = block_hit(ADDR, AEN, BASE_ADDRESS_SELECT);
        // one write per strobe, on its falling edge
        wr_pulse = hit && !IOW_N && st_r.iow_prev;
        src_now = src_bit(INTERRUPT_SOURCE_SELECT,
            ISOLATED_INPUT_BITS, TTL_INPUT_BITS);
        if (INTERRUPT_EDGE_SELECT == idp_pkg::EDGE_FALLING) begin
            edge_seen = st_r.src_prev && !src_now;
        end else begin
            edge_seen = !st_r.src_prev && src_now;
        end
        line_idx = INTERRUPT_LINE_SELECT - idp_pkg::IRQ_LINE_MIN;

        st_nxt = st_r;
        st_nxt.iow_prev = IOW_N;
        st_nxt.src_prev = src_now;
        // reads return the pins, never the output latches
        st_nxt.rd_oe = hit && !IOR_N;
        st_nxt.rdata = in_byte(ADDR[idp_pkg::OFS_MSB:0],
            ISOLATED_INPUT_BITS, TTL_INPUT_BITS);
        st_nxt.irq = idp_pkg::IRQ_IDLE;
        if (edge_seen
            && INTERRUPT_LINE_SELECT >= idp_pkg::IRQ_LINE_MIN
            && INTERRUPT_LINE_SELECT <= idp_pkg::IRQ_LINE_MAX) begin
            st_nxt.irq = idp_pkg::IRQ_ONE << line_idx;
        end

        wr.wr_en = wr_pulse;
        wr.wr_ofs = ADDR[idp_pkg::OFS_MSB:0];
        wr.wr_data = DATA_IN;
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            st_r.iow_prev <= 1'b1;
            st_r.src_prev <= 1'b0;
            st_r.rdata <= idp_pkg::DATA_RESET;
            st_r.rd_oe <= 1'b0;
            st_r.irq <= idp_pkg::IRQ_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ======================================================
    // output latches
    idp_out_latch u_latch (
        .clk(CLK_SYS),
        .rst(RESET),
        .wr(wr.lat)
    );

    assign DATA_OUT = st_r.rdata;
    assign DATA_OE = st_r.rd_oe;
    assign IRQ_LINES = st_r.irq;
    assign ISOLATED_OUTPUT_BITS = wr.iso_q;
    assign TTL_OUTPUT_BITS = wr.ttl_q;
endmodule : idp_top

/* test/idp_top_sva.sv */
// assertions on the i/o port pins
`timescale 1ns/100ps
module idp_top_sva (
    // bus and straps
    input wire logic CLK_SYS, RESET, AEN, IOW_N, IOR_N, DATA_OE,
    input wire logic INTERRUPT_EDGE_SELECT,
    input wire logic [9:0] ADDR,
    input wire logic [7:0] DATA_IN, DATA_OUT, BASE_ADDRESS_SELECT,
    input wire logic [1:0] INTERRUPT_SOURCE_SELECT,
    input wire logic [2:0] INTERRUPT_LINE_SELECT,
    // channels
    input wire logic [15:0] ISOLATED_INPUT_BITS, TTL_INPUT_BITS,
    input wire logic [15:0] ISOLATED_OUTPUT_BITS, TTL_OUTPUT_BITS,
    input wire logic [5:0] IRQ_LINES
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    logic hit, on, src, rise, fall;
    logic [3:0] ch;
    logic [2:0] lidx;
    logic [31:0] ins, outs;
    assign hit = !AEN && ADDR[9:2] == BASE_ADDRESS_SELECT;
    assign on = INTERRUPT_LINE_SELECT >= 3'h2;
    assign ins = {TTL_INPUT_BITS, ISOLATED_INPUT_BITS};
    assign outs = {TTL_OUTPUT_BITS, ISOLATED_OUTPUT_BITS};
    assign ch = {ins[17:16], ins[1:0]};
    assign src = ch[INTERRUPT_SOURCE_SELECT];
    assign lidx = INTERRUPT_LINE_SELECT - 3'h2;
    assign fall = INTERRUPT_EDGE_SELECT;
    assign rise = !INTERRUPT_EDGE_SELECT;
    a_write_byte: assert property (hit && !IOW_N && $past(IOW_N) |=>
        8'(outs >> {$past(ADDR[1:0]), 3'h0}) == $past(DATA_IN))
        else $error("written byte not on pins");
    a_out_hold: assert property (!(hit && !IOW_N && $past(IOW_N)) |=>
        $stable(outs)) else $error("outputs moved without write");
    a_read_data: assert property (hit && !IOR_N |=> DATA_OE && DATA_OUT ==
        8'($past(ins) >> {$past(ADDR[1:0]), 3'h0})) else $error("bad read");
    a_oe_drop: assert property (!(hit && !IOR_N) |=> !DATA_OE)
        else $error("data driven without read");
    a_irq_edge: assert property (on && (fall ? $fell(src) : $rose(src))
        |=> IRQ_LINES == 6'h01 << $past(lidx))
        else $error("irq pulse wrong");
    a_irq_wrong_dir: assert property (rise && $fell(src)
        or fall && $rose(src) |=> IRQ_LINES == 6'h00) else $error("irq on edge");
    a_irq_off: assert property (!on |=> IRQ_LINES == 6'h00)
        else $error("irq while disabled");
    a_irq_cause: assert property ($stable(src) |=> IRQ_LINES == 6'h00)
        else $error("irq without edge");
endmodule : idp_top_sva
bind idp_top idp_top_sva idp_top_sva_i (.*);

/* test/idp_host.sv */
// host bus model issuing i/o cycles
`timescale 1ns/100ps
module idp_host (
    // bus
    input wire logic clk,
    input wire logic [7:0] rd_data,
    input wire logic rd_oe,
    output logic [9:0] addr = 10'h000,
    output logic [7:0] wr_data = 8'h00,
    output logic aen = 1'b0, iow_n = 1'b1, ior_n = 1'b1
);
    task automatic wr(logic [9:0] a, logic [7:0] d, logic e);
        addr = a;
        wr_data = d;
        aen = e;
        iow_n = 1'b0;
        @(negedge clk);
        iow_n = 1'b1;
        wr_data = ~d;
        @(negedge clk);
    endtask : wr
    task automatic rd(logic [9:0] a, output logic [7:0] d, output logic o);
        addr = a;
        aen = 1'b0;
        ior_n = 1'b0;
        @(negedge clk);
        d = rd_data;
        o = rd_oe;
        ior_n = 1'b1;
        @(negedge clk);
    endtask : rd
endmodule : idp_host

/* test/tb_idp_top.sv */
// self-checking bench for the i/o port
`timescale 1ns/100ps
module tb_idp_top;
    logic clk = 1'b0, rst = 1'b1, edg = 1'b0, aen, iow_n, ior_n;
    logic [9:0] addr;
    logic [7:0] wd, rd, base = 8'hC0, got;
    logic [1:0] srcs = 2'h0;
    logic [2:0] line = 3'h2;
    logic [4:0] sh;
    logic [5:0] irq, seen;
    logic [31:0] seed = 32'h83315859, r, pins = 32'h0, want = 32'h0;
    wire [31:0] outs;
    wire oe;
    logic oe_got;
    int errors = 0, tests_run = 0, n;
    always #50 clk = ~clk;
    idp_host idp_host_i (.clk(clk), .rd_data(rd), .rd_oe(oe), .addr(addr),
        .wr_data(wd),
        .aen(aen), .iow_n(iow_n), .ior_n(ior_n));
    idp_top idp_top_i (.CLK_SYS(clk), .RESET(rst), .ADDR(addr), .AEN(aen),
        .IOW_N(iow_n), .IOR_N(ior_n), .DATA_IN(wd), .DATA_OUT(rd),
        .DATA_OE(oe),
        .BASE_ADDRESS_SELECT(base), .INTERRUPT_SOURCE_SELECT(srcs),
        .INTERRUPT_EDGE_SELECT(edg), .INTERRUPT_LINE_SELECT(line),
        .ISOLATED_INPUT_BITS(pins[15:0]), .TTL_INPUT_BITS(pins[31:16]),
        .ISOLATED_OUTPUT_BITS(outs[15:0]), .TTL_OUTPUT_BITS(outs[31:16]),
        .IRQ_LINES(irq));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [5:0] irq_of(logic [2:0] l);
        return (l < 3'h2) ? 6'h00 : 6'h01 << (l - 3'h2);
    endfunction : irq_of
    task automatic chk(string what, logic [31:0] e, logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask : chk
    task automatic print_verdict();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    // or of irq over the three cycles that hold any pulse
    task automatic watch(logic [5:0] e);
        seen = 6'h00;
        repeat (3) begin
            @(negedge clk);
            seen |= irq;
        end
        chk("irq lines", e, seen);
    endtask : watch
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("outputs at reset", 32'h0, outs);
        // writes: hit, other base, dma cycle
        for (n = 0; n < 24; n++) begin
            r = rnd();
            if (n >= 12)
                base = {2'h2, r[21:16]};
            idp_host_i.wr({(n % 3 == 1) ? ~base : base, r[1:0]}, r[15:8],
                n % 3 == 2);
            if (n % 3 == 0)
                want[{r[1:0], 3'h0} +: 8] = r[15:8];
            chk("output pins", want, outs);
        end
        for (n = 0; n < 8; n++) begin
            pins = rnd();
            idp_host_i.rd({base, n[1:0]}, got, oe_got);
            chk("read byte", 8'(pins >> {n[1:0], 3'h0}), got);
            chk("read enable", 32'h1, oe_got);
            chk("read enable off", 32'h0, oe);
        end
        // every source, edge and line setting
        for (n = 0; n < 64; n++) begin
            r = rnd();
            pins = {r[31:18], {2{n[2]}}, r[15:2], {2{n[2]}}};
            @(negedge clk);
            {line, edg, srcs} = n[5:0];
            sh = {n[1], 4'h0} | 5'(n[0]);
            repeat (2) @(negedge clk);
            pins[sh] = ~n[2];
            watch(irq_of(line));
            pins[sh] = n[2];
            pins[sh ^ 5'h01] = ~n[2];
            watch(6'h00);
        end
        print_verdict();
    end
endmodule : tb_idp_top
